// ### core/flash_guard.sv
// flash segment code protection guard with an axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module flash_guard
	import flash_guard_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int CFG_PAGES = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// request from the core
	input wire logic req_valid,
	input wire req_type req,
	output logic req_ready,
	// verdict to the core
	output logic resp_valid,
	output resp_type resp,
	// granted command to the flash
	output logic flash_valid,
	output req_type flash_cmd
);

	localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
	localparam logic [PAGE_W-1:0] CFG_FIRST =
		PAGE_W'((1 << PAGE_W) - CFG_PAGES);

	// register file
	logic [SEC_W-1:0] sec_r [2];
	logic [LIMIT_W-1:0] lim_r [2];
	logic [MODE_W-1:0] mode_r;
	logic deny_seen_r;
	logic [15:0] deny_count_r;
	cause_type last_cause_r;

	// axi state
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	// mode decode
	part_mode_type pmode;
	logic dual;
	logic guarded;
	logic active_part;
	logic alt_en;
	assign pmode = part_mode_type'(mode_r[MODE_SEL +: 2]);
	assign dual = (pmode != PART_SINGLE);
	assign guarded = (pmode == PART_PROTECTED) || (pmode == PART_PRIVILEGED);
	assign active_part = dual & mode_r[MODE_ACTIVE];
	assign alt_en = mode_r[MODE_ALT_EN];

	// boot size in pages, zero when no boot segment
	function automatic logic [LIMIT_W-1:0] boot_pages(
		input logic [LIMIT_W-1:0] lim, input logic alt
	);
		logic [LIMIT_W-1:0] n;
		n = lim;
		if (lim != '0 && alt && lim < LIMIT_W'(ALT_MIN_PAGES)) begin
			n = LIMIT_W'(ALT_MIN_PAGES);
		end else if (lim != '0 && lim < LIMIT_W'(BOOT_MIN_PAGES)) begin
			n = LIMIT_W'(BOOT_MIN_PAGES);
		end
		return n;
	endfunction

	// segment that holds a word address under one partition's limit
	function automatic seg_type seg_of(
		input logic [ADDR_W-1:0] a,
		input logic [LIMIT_W-1:0] lim, input logic alt
	);
		logic [LIMIT_W-1:0] n;
		logic [PAGE_W-1:0] pg;
		logic upper;
		seg_type s;
		n = boot_pages(lim, alt);
		pg = a[ADDR_W-1:PAGE_SHIFT];
		upper = a[PAGE_SHIFT-1];
		s = SEG_GENERAL;
		if (pg >= CFG_FIRST) begin
			s = SEG_CONFIG;
		end else if (n != '0 && LIMIT_W'(pg) < n) begin
			// boot pages hold 512 words each
			if (LIMIT_W'(pg) == n - 1'b1 && alt) begin
				s = upper ? SEG_VOID : SEG_ALT;
			end else if (LIMIT_W'(pg) == n - 1'b1 && upper) begin
				s = SEG_VOID;
			end else if (pg == '0 && !upper) begin
				s = SEG_VECTOR;
			end else begin
				s = SEG_BOOT;
			end
		end else if (pg == '0 && !upper) begin
			s = SEG_VECTOR;
		end
		return s;
	endfunction
	// request decode; config of the target partition applies
	logic tgt_part;
	logic [SEC_W-1:0] sec;
	logic [LIMIT_W-1:0] lim;
	logic boot_en;
	seg_type tgt_seg;
	seg_type src_seg;
	logic src_boot;
	logic src_gen;
	logic tgt_boot;
	logic tgt_gen;
	logic last_boot_page;
	logic [1:0] boot_cp;
	logic [1:0] gen_cp;
	logic [1:0] cfg_cp;
	logic [1:0] tgt_cp;
	logic tgt_wp;
	logic is_write;
	logic same_seg;
	assign tgt_part = dual & req.part;
	assign sec = sec_r[tgt_part];
	assign lim = lim_r[tgt_part];
	assign boot_en = (lim != '0);
	assign tgt_seg = seg_of(req.addr[ADDR_W-1:0], lim, alt_en);
	assign src_seg = seg_of(req.src_addr[ADDR_W-1:0], lim_r[active_part],
		alt_en);
	assign src_boot = (src_seg == SEG_BOOT) || (src_seg == SEG_VECTOR && boot_en);
	assign src_gen = (src_seg == SEG_GENERAL) ||
		(src_seg == SEG_VECTOR && !boot_en);
	// vector table joins the boot segment only when one exists
	assign tgt_boot = (tgt_seg == SEG_BOOT) ||
		(tgt_seg == SEG_VECTOR && boot_en);
	assign tgt_gen = (tgt_seg == SEG_GENERAL) ||
		(tgt_seg == SEG_VECTOR && !boot_en);
	assign last_boot_page = (tgt_seg == SEG_ALT) ||
		(boot_en && LIMIT_W'(req.addr[ADDR_W-1:PAGE_SHIFT]) ==
		boot_pages(lim, alt_en) - 1'b1);
	assign boot_cp = sec[SEC_BOOT_CP +: 2];
	assign gen_cp = sec[SEC_GEN_CP +: 2];
	assign cfg_cp = sec[SEC_CFG_CP +: 2];
	assign tgt_cp = tgt_boot ? boot_cp : (tgt_gen ? gen_cp :
		(tgt_seg == SEG_CONFIG ? cfg_cp : 2'b00));
	// alternate page stays outside boot write lock
	assign tgt_wp = (tgt_boot && sec[SEC_BOOT_WP]) ||
		(tgt_gen && sec[SEC_GEN_WP]) ||
		(tgt_seg == SEG_CONFIG && sec[SEC_CFG_WP]);
	assign is_write = (req.op == OP_PROGRAM) || (req.op == OP_ERASE);
	assign same_seg = (src_boot && tgt_boot) || (src_gen && tgt_gen);

	// verdict
	logic deny_void;
	logic deny_part;
	logic deny_wp;
	logic deny_cp;
	logic deny_priv;
	logic boot_override;
	logic grant;
	cause_type cause;
	assign deny_void = (tgt_seg == SEG_VOID);
	assign deny_part = (dual && req.op == OP_FETCH &&
		req.part != active_part) ||
		(guarded && is_write && tgt_part == 1'b0);
	assign boot_override = src_boot && last_boot_page && is_write;
	assign deny_wp = is_write && !boot_override && (tgt_wp ||
		(tgt_seg == SEG_VECTOR &&
		(sec[SEC_BOOT_WP] || sec[SEC_GEN_WP])));
	// general code cannot reach protected boot or config; boot reaches more
	assign deny_cp = !same_seg && req.op != OP_FETCH && tgt_cp != 2'b00 &&
		!(src_boot && !tgt_boot && tgt_cp != 2'b11) &&
		!boot_override;
	assign deny_priv = pmode == PART_PRIVILEGED && req.op != OP_FETCH &&
		((src_boot && tgt_gen) || (src_gen && tgt_boot));
	assign grant = !(deny_void || deny_part || deny_wp || deny_cp ||
		deny_priv);
	assign cause = deny_void ? CAUSE_UNUSABLE :
		deny_part ? CAUSE_PARTITION :
		deny_wp ? CAUSE_WRITE_PROT :
		deny_priv ? CAUSE_PRIVILEGE :
		deny_cp ? CAUSE_CODE_PROT : CAUSE_NONE;

	logic take;
	assign take = req_valid & req_ready;
	// verdict and flash forwarding, one cycle after the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp <= '0;
			flash_valid <= 1'b0;
			flash_cmd <= '0;
		end else begin
			req_ready <= 1'b1;
			resp_valid <= take;
			resp <= take ? resp_type'{grant, cause, tgt_seg} : resp;
			flash_valid <= take & grant;
			flash_cmd <= (take & grant) ? req : flash_cmd;
		end
	end

	// denial status; new denial wins over a clear in the same cycle
	logic [31:0] wmask;
	logic wr_fire;
	logic status_clear;
	assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
		{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign status_clear = wr_fire && aw_addr_r == STATUS_OFS &&
		w_strb_r[0] && w_data_r[0];
	logic denied_now;
	assign denied_now = take & ~grant;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deny_seen_r <= 1'b0;
			deny_count_r <= '0;
			last_cause_r <= CAUSE_NONE;
		end else begin
			deny_seen_r <= denied_now | (deny_seen_r & ~status_clear);
			if (denied_now) begin
				last_cause_r <= cause;
			end
			if (denied_now && deny_count_r != '1) begin
				deny_count_r <= deny_count_r + 16'h0001;
			end
		end
	end

	// axi write channels, taken in either order
	logic wr_known;
	assign wr_known = (aw_addr_r == SEC_P1_OFS) || (aw_addr_r == LIM_P1_OFS) ||
		(aw_addr_r == SEC_P2_OFS) || (aw_addr_r == LIM_P2_OFS) ||
		(aw_addr_r == MODE_OFS) || (aw_addr_r == STATUS_OFS) ||
		(aw_addr_r == GEOM_OFS);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_full_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_full_r & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
			end
		end
	end

	// writable registers with byte lanes
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [31:0] m
	);
		return (old & ~m) | (nw & m);
	endfunction

	logic [31:0] sec1_nxt;
	logic [31:0] sec2_nxt;
	logic [31:0] lim1_nxt;
	logic [31:0] lim2_nxt;
	logic [31:0] mode_nxt;
	assign sec1_nxt = merge(32'(sec_r[0]), w_data_r, wmask);
	assign sec2_nxt = merge(32'(sec_r[1]), w_data_r, wmask);
	assign lim1_nxt = merge(32'(lim_r[0]), w_data_r, wmask);
	assign lim2_nxt = merge(32'(lim_r[1]), w_data_r, wmask);
	assign mode_nxt = merge(32'(mode_r), w_data_r, wmask);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_r[0] <= SEC_RESET;
			sec_r[1] <= SEC_RESET;
			lim_r[0] <= LIM_RESET;
			lim_r[1] <= LIM_RESET;
			mode_r <= MODE_RESET;
		end else if (wr_fire) begin
			if (aw_addr_r == SEC_P1_OFS) begin
				sec_r[0] <= sec1_nxt[SEC_W-1:0];
			end
			if (aw_addr_r == SEC_P2_OFS) begin
				sec_r[1] <= sec2_nxt[SEC_W-1:0];
			end
			if (aw_addr_r == LIM_P1_OFS) begin
				lim_r[0] <= lim1_nxt[LIMIT_W-1:0];
			end
			if (aw_addr_r == LIM_P2_OFS) begin
				lim_r[1] <= lim2_nxt[LIMIT_W-1:0];
			end
			if (aw_addr_r == MODE_OFS) begin
				mode_r <= mode_nxt[MODE_W-1:0];
			end
		end
	end

	// read path
	logic [LIMIT_W-1:0] act_boot;
	logic [31:0] rd_word;
	logic rd_known;
	assign act_boot = boot_pages(lim_r[active_part], alt_en);
	assign rd_known = (s_axi_araddr[7:2] <= GEOM_OFS[7:2]);
	always_comb begin
		unique case ({s_axi_araddr[7:2], 2'b00})
			SEC_P1_OFS: rd_word = 32'(sec_r[0]);
			LIM_P1_OFS: rd_word = 32'(lim_r[0]);
			SEC_P2_OFS: rd_word = 32'(sec_r[1]);
			LIM_P2_OFS: rd_word = 32'(lim_r[1]);
			MODE_OFS: rd_word = 32'(mode_r);
			STATUS_OFS: rd_word = {deny_count_r, 12'h000,
				last_cause_r, deny_seen_r};
			GEOM_OFS: rd_word = {3'h0, act_boot, 16'(CFG_FIRST)};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ### core/flash_guard_pkg.sv
// package: constants, types and register map of the flash segment guard
package flash_guard_pkg;

	// geometry
	localparam int PAGE_WORDS = 512;
	localparam int HALF_PAGE_WORDS = 256;
	localparam int PAGE_SHIFT = 9;
	localparam int ALT_MIN_PAGES = 2;
	localparam int BOOT_MIN_PAGES = 1;
	localparam int LIMIT_W = 13;

	// register byte offsets
	localparam logic [7:0] SEC_P1_OFS = 8'h00;
	localparam logic [7:0] LIM_P1_OFS = 8'h04;
	localparam logic [7:0] SEC_P2_OFS = 8'h08;
	localparam logic [7:0] LIM_P2_OFS = 8'h0c;
	localparam logic [7:0] MODE_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] GEOM_OFS = 8'h18;

	// security config word fields
	localparam int SEC_BOOT_WP = 0;
	localparam int SEC_BOOT_CP = 1;
	localparam int SEC_GEN_WP = 3;
	localparam int SEC_GEN_CP = 4;
	localparam int SEC_CFG_WP = 6;
	localparam int SEC_CFG_CP = 7;
	localparam int SEC_W = 9;

	// mode register fields
	localparam int MODE_SEL = 0;
	localparam int MODE_ACTIVE = 2;
	localparam int MODE_ALT_EN = 3;
	localparam int MODE_W = 4;

	// reset values
	localparam logic [SEC_W-1:0] SEC_RESET = 9'h000;
	localparam logic [LIMIT_W-1:0] LIM_RESET = 13'h0000;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PART_SINGLE = 2'b00,
		PART_DUAL = 2'b01,
		PART_PROTECTED = 2'b10,
		PART_PRIVILEGED = 2'b11
	} part_mode_type;

	typedef enum logic [1:0] {
		OP_FETCH = 2'b00,
		OP_READ = 2'b01,
		OP_PROGRAM = 2'b10,
		OP_ERASE = 2'b11
	} op_type;

	typedef enum logic [2:0] {
		SEG_VECTOR = 3'd0,
		SEG_BOOT = 3'd1,
		SEG_ALT = 3'd2,
		SEG_GENERAL = 3'd3,
		SEG_CONFIG = 3'd4,
		SEG_VOID = 3'd5
	} seg_type;

	typedef enum logic [2:0] {
		CAUSE_NONE = 3'd0,
		CAUSE_UNUSABLE = 3'd1,
		CAUSE_PARTITION = 3'd2,
		CAUSE_WRITE_PROT = 3'd3,
		CAUSE_CODE_PROT = 3'd4,
		CAUSE_PRIVILEGE = 3'd5
	} cause_type;

	typedef struct packed {
		op_type op;
		logic part;
		logic [15:0] addr;
		logic [15:0] src_addr;
	} req_type;

	typedef struct packed {
		logic grant;
		cause_type cause;
		seg_type seg;
	} resp_type;

endpackage

// ### test/core_model.sv
// behavioural processor core issuing flash requests
`timescale 1ns/100ps
`default_nettype none
module core_model
	import flash_guard_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// command from the bench
	input wire logic cmd_valid,
	input wire req_type cmd,
	// request to the guard
	output logic req_valid,
	input wire logic req_ready,
	output req_type req
);
	// request held until taken; junk on the bus between requests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_valid <= 1'b0;
			req <= '0;
		end else if (!req_valid || req_ready) begin
			req_valid <= cmd_valid;
			req <= cmd_valid ? cmd : ~req;
		end
	end
endmodule
`default_nettype wire

// ### test/flash_guard_chk.sv
// assertions on the request and verdict ports of the flash guard
`timescale 1ns/100ps
`default_nettype none
module flash_guard_chk
	import flash_guard_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int CFG_PAGES = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_valid,
	input wire req_type req,
	input wire logic req_ready,
	input wire logic resp_valid,
	input wire resp_type resp,
	input wire logic flash_valid,
	input wire req_type flash_cmd
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	localparam int TOP = (1 << (ADDR_W - 9)) - CFG_PAGES;
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_forward;
		s_take ##1 flash_valid;
	endsequence
	a_verdict_next: assert property (s_take |=> resp_valid)
		else $error("no verdict one cycle after a request");
	a_verdict_cause: assert property (
		resp_valid |-> $past(req_valid & req_ready))
		else $error("verdict without a request");
	a_grant_fwd: assert property (resp_valid |->
		flash_valid == resp.grant)
		else $error("flash strobe differs from grant");
	a_cmd_copy: assert property (s_forward |-> flash_cmd == $past(req))
		else $error("forwarded command differs from request");
	a_cause_none: assert property (resp_valid |->
		resp.grant == (resp.cause == CAUSE_NONE))
		else $error("grant and cause disagree");
	a_void_refused: assert property (
		resp_valid && resp.seg == SEG_VOID |->
		!resp.grant && resp.cause == CAUSE_UNUSABLE)
		else $error("unusable memory was not refused");
	a_config_top: assert property (
		(s_take and (req.addr[15:9] >= TOP)) |=>
		resp.seg == SEG_CONFIG)
		else $error("top page not seen as config segment");
	a_alt_unlocked: assert property (
		resp_valid && resp.seg == SEG_ALT |->
		resp.cause != CAUSE_WRITE_PROT)
		else $error("alternate table page write locked");
	a_fetch_nowp: assert property (
		(s_take and (req.op == OP_FETCH)) |=>
		resp.cause != CAUSE_WRITE_PROT)
		else $error("fetch refused by write lock");
endmodule
bind flash_guard flash_guard_chk #(.ADDR_W(ADDR_W), .CFG_PAGES(CFG_PAGES))
	u_chk (.aclk, .aresetn, .req_valid, .req, .req_ready, .resp_valid,
	.resp, .flash_valid, .flash_cmd);
`default_nettype wire

// ### test/tb.sv
// self-checking testbench for the flash segment guard
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	import flash_guard_pkg::*;
	logic aclk = 0, aresetn = 0, cmd_valid = 0, s_axi_awvalid = 0;
	logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, alt = 0, dualm = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, r;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, req_ready, resp_valid, flash_valid, req_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [LIMIT_W-1:0] lim [2] = '{13'h0, 13'h0};
	resp_type resp;
	req_type flash_cmd, req, cmd = '0;
	int n_errors = 0, n_tests = 0, seed = 80, i;
	int n_deny = 0;
	cause_type last_c = CAUSE_NONE;
	always #4 aclk = ~aclk;
	core_model u_core (.aclk, .aresetn, .cmd_valid, .cmd, .req_valid,
		.req_ready, .req);
	flash_guard dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req,
		.req_ready, .resp_valid, .resp, .flash_valid, .flash_cmd);
	function automatic seg_type seg_of(logic [15:0] a, logic p);
		logic [LIMIT_W-1:0] l;
		l = lim[p & dualm];
		if (alt && l == 1) l = 2;
		if (a[15:9] == 7'h7f) return SEG_CONFIG;
		if (a < 16'h0100) return SEG_VECTOR;
		if (a[15:9] >= l) return SEG_GENERAL;
		if (a[15:9] == l - 1 && a[8]) return SEG_VOID;
		if (a[15:9] == l - 1 && alt) return SEG_ALT;
		return SEG_BOOT;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic pa, pw;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && s_axi_awready === 1'b1) begin
				pa = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready === 1'b1) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
	endtask
	task automatic rq(input op_type o, input logic p, input logic [15:0] a,
		input logic [15:0] s, input logic g, input cause_type c);
		int k;
		req_type e;
		e = '{o, p, a, s};
		if (!g) begin
			n_deny++;
			last_c = c;
		end
		@(posedge aclk);
		cmd <= e;
		cmd_valid <= 1'b1;
		@(posedge aclk);
		cmd_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge aclk);
			#1;
			k++;
		end while (resp_valid !== 1'b1 && k < 8);
		`CHK(resp_valid, 1'b1)
		`CHK(resp.grant, g)
		`CHK(resp.cause, c)
		`CHK(resp.seg, seg_of(a, p))
		`CHK(flash_valid, g)
		if (g) `CHK(flash_cmd, e)
	endtask
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(SEC_P1_OFS, 0);
		rd(MODE_OFS, 0);
		wr(8'h1c, 32'h1, RESP_SLVERR);
		rd(8'h1c, 0, RESP_SLVERR);
		lim[0] = 2;
		wr(LIM_P1_OFS, 2);
		rd(GEOM_OFS, 32'h0002_007f);
		for (i = 0; i < 20; i++) begin
			r = $random(seed);
			rq(op_type'(r[1:0]), 0, {7'(2 + r[31:9] % 125), r[8:0]},
				16'h2000 + r[20:10], 1, CAUSE_NONE);
		end
		rq(OP_READ, 0, 16'h0300, 16'h2000, 0, CAUSE_UNUSABLE);
		rq(OP_READ, 0, 16'hfe00, 16'h2000, 1, CAUSE_NONE);
		wr(SEC_P1_OFS, 32'h12);
		rq(OP_READ, 0, 16'h2000, 16'h0100, 1, CAUSE_NONE);
		rq(OP_READ, 0, 16'h0100, 16'h2000, 0, CAUSE_CODE_PROT);
		wr(SEC_P1_OFS, 32'h30);
		rq(OP_READ, 0, 16'h2000, 16'h0100, 0, CAUSE_CODE_PROT);
		alt = 1;
		lim[0] = 1;
		wr(MODE_OFS, 32'h8);
		wr(LIM_P1_OFS, 1);
		rd(GEOM_OFS, 32'h0002_007f);
		wr(SEC_P1_OFS, 32'h1);
		rq(OP_PROGRAM, 0, 16'h0200, 16'h2000, 1, CAUSE_NONE);
		rq(OP_PROGRAM, 0, 16'h0100, 16'h2000, 0, CAUSE_WRITE_PROT);
		rq(OP_PROGRAM, 0, 16'h0000, 16'h0100, 0, CAUSE_WRITE_PROT);
		rq(OP_ERASE, 0, 16'h0300, 16'h0100, 0, CAUSE_UNUSABLE);
		wr(SEC_P1_OFS, 32'h7);
		rq(OP_ERASE, 0, 16'h0200, 16'h0100, 1, CAUSE_NONE);
		alt = 0;
		lim[0] = 0;
		wr(MODE_OFS, 0);
		wr(LIM_P1_OFS, 0);
		wr(SEC_P1_OFS, 32'h8);
		rq(OP_PROGRAM, 0, 16'h0000, 16'h2000, 0, CAUSE_WRITE_PROT);
		wr(SEC_P1_OFS, 32'hb0);
		rq(OP_READ, 0, 16'hfe00, 16'h2000, 0, CAUSE_CODE_PROT);
		rq(OP_READ, 0, 16'h3000, 16'h2000, 1, CAUSE_NONE);
		dualm = 1;
		wr(MODE_OFS, 32'h1);
		wr(SEC_P1_OFS, 0);
		rq(OP_FETCH, 1, 16'h2000, 16'h2000, 0, CAUSE_PARTITION);
		rq(OP_READ, 1, 16'h2000, 16'h2000, 1, CAUSE_NONE);
		wr(SEC_P2_OFS, 32'h8);
		rq(OP_PROGRAM, 1, 16'h2000, 16'h2000, 0, CAUSE_WRITE_PROT);
		rq(OP_PROGRAM, 0, 16'h2000, 16'h2000, 1, CAUSE_NONE);
		wr(MODE_OFS, 32'h2);
		wr(SEC_P2_OFS, 0);
		rq(OP_ERASE, 0, 16'h2000, 16'h2000, 0, CAUSE_PARTITION);
		rq(OP_ERASE, 1, 16'h2000, 16'h2000, 1, CAUSE_NONE);
		lim[0] = 2;
		wr(LIM_P1_OFS, 2);
		wr(MODE_OFS, 32'h3);
		rq(OP_READ, 0, 16'h2000, 16'h0100, 0, CAUSE_PRIVILEGE);
		rq(OP_READ, 0, 16'h0100, 16'h2000, 0, CAUSE_PRIVILEGE);
		rd(STATUS_OFS, {16'(n_deny), 12'h000, last_c, 1'b1});
		wr(STATUS_OFS, 32'h1);
		rd(STATUS_OFS, {16'(n_deny), 12'h000, last_c, 1'b0});
		print_verdict();
	end
endmodule
`default_nettype wire
